// ==== common/logic_equation_engine_pkg.sv ====
/*
 * Package for the logic equation engine: sizes, signal list layout, register
 * offsets, field positions, reset values and the gate operator encoding.
 * Assumes a 32-bit APB register bus with byte addresses.
 */
package logic_equation_engine_pkg;

   // sizes of the equation bank and of the selectable signal list
   localparam int NUM_EQ   = 8;
   localparam int EQ_IDX_W = 3;
   localparam int NUM_IN   = 4;
   localparam int EXT_W    = 16;
   localparam int SIG_W    = 5;
   localparam int DLY_W    = 16;
   localparam int ADDR_W   = 8;

   // signal list: external signals, then direct results, then latched results
   localparam int SIG_EXT_BASE = 0;
   localparam int SIG_RES_BASE = 16;
   localparam int SIG_LAT_BASE = 24;
   localparam int SIG_COUNT    = 32;

   // register layout: one block of four words for each equation slot
   localparam logic [ADDR_W-1:0] EQ_STRIDE = 8'h10;
   localparam logic [ADDR_W-1:0] MAP_END   = 8'h80;
   localparam logic [3:0]        OFS_CFG   = 4'h0;
   localparam logic [3:0]        OFS_RST   = 4'h4;
   localparam logic [3:0]        OFS_DLY   = 4'h8;
   localparam logic [3:0]        OFS_STAT  = 4'hc;

   // input configuration word fields
   localparam int CFG_SEL_POS = 0;
   localparam int CFG_INV_POS = 20;
   localparam int CFG_OP_POS  = 24;

   // latch reset configuration word fields
   localparam int RST_SEL_POS = 0;
   localparam int RST_INV_POS = 8;

   // delay word fields, both counted in evaluation passes
   localparam int DLY_ON_POS  = 0;
   localparam int DLY_OFF_POS = 16;

   // status word fields
   localparam int STAT_RES_POS  = 0;
   localparam int STAT_LAT_POS  = 1;
   localparam int STAT_GATE_POS = 2;
   localparam int STAT_CNT_POS  = 16;

   // values after reset
   localparam logic [31:0]      CFG_RESET = 32'h0000_0000;
   localparam logic [31:0]      RST_RESET = 32'h0000_0000;
   localparam logic [31:0]      DLY_RESET = 32'h0000_0000;
   localparam logic [DLY_W-1:0] CNT_RESET = 16'h0000;

   // gate operator applied to the four conditioned inputs
   typedef enum logic [1:0] {
      GATE_AND  = 2'b00,
      GATE_OR   = 2'b01,
      GATE_NAND = 2'b10,
      GATE_NOR  = 2'b11
   } gate_op_e;

endpackage

// ==== verilog/logic_equation_engine.sv ====
/*
 * Logic equation engine: a bank of configurable equations with selectable,
 * invertible inputs, a gate, on and off delay timers and a reset-dominant
 * latch, evaluated one slot per clock in ascending order, plus an APB slave.
 * One pass over all slots takes NUM_EQ clocks. Both delays count passes, so a
 * delay setting of N lets the output follow on the N+1th differing pass.
 * A slot reading a lower slot sees this pass's result; a slot reading itself
 * or a higher slot sees the result of the previous pass.
 * Results, latched results and their complement all come from flip-flops.
 * Assumes the external signal groups come from outside this clock domain and
 * reach the engine two clocks late through the synchronisers.
 * Assumes the APB master runs on mclk_in and needs no wait states: every
 * access ends in its first access cycle, and read data and the error flag
 * are captured at the setup edge.
 * Assumes the latch reset source is a level: it is looked at once per pass,
 * so a pulse shorter than a pass may be missed.
 */
`timescale 1ns/1ps
`default_nettype none

module logic_equation_engine
   import logic_equation_engine_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              reset_in,
   // selectable device signals
   input  wire logic [3:0]        pickup_in,
   input  wire logic [3:0]        prot_state_in,
   input  wire logic [1:0]        breaker_state_in,
   input  wire logic [1:0]        alarm_in,
   input  wire logic [3:0]        module_input_in,
   // equation outputs
   output logic [NUM_EQ-1:0]      equation_result_output_out,
   output logic [NUM_EQ-1:0]      latched_result_out,
   output logic [NUM_EQ-1:0]      latched_result_inv_out,
   output logic                   pass_done_out,
   // apb slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic [31:0]            prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out
);

   // picks one signal of the list by its select code
   function automatic logic pick_signal(input logic [SIG_COUNT-1:0] list,
                                        input logic [SIG_W-1:0]     sel);
      pick_signal = list[sel];
   endfunction

   // picks one signal of the list and applies its inversion option
   function automatic logic cond_signal(input logic [SIG_COUNT-1:0] list,
                                        input logic [SIG_W-1:0]     sel,
                                        input logic                 inv);
      cond_signal = pick_signal(list, sel) ^ inv;
   endfunction

   // applies the gate operator to the conditioned inputs
   function automatic logic gate_eval(input logic [1:0]        op,
                                      input logic [NUM_IN-1:0] cond);
      logic result;
      result = 1'b0;
      unique case (gate_op_e'(op))
         GATE_AND: begin
            result = &cond;
         end
         GATE_OR: begin
            result = |cond;
         end
         GATE_NAND: begin
            result = ~(&cond);
         end
         GATE_NOR: begin
            result = ~(|cond);
         end
      endcase
      gate_eval = result;
   endfunction

   // true when the address lands inside the mapped, word aligned range
   function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
      addr_mapped = (addr < MAP_END) && (addr[1:0] == 2'b00);
   endfunction

   // external signal synchronisers and their assembled view
   logic [EXT_W-1:0]    ext_raw;
   logic [EXT_W-1:0]    ext_s1_q;
   logic [EXT_W-1:0]    ext_s2_q;

   // configuration storage, one word of each kind per slot
   logic [31:0]         cfg_q [NUM_EQ];
   logic [31:0]         rst_q [NUM_EQ];
   logic [31:0]         dly_q [NUM_EQ];

   // per slot evaluation state
   logic [NUM_EQ-1:0]   res_q;
   logic [NUM_EQ-1:0]   lat_q;
   logic [NUM_EQ-1:0]   lat_inv_q;
   logic [NUM_EQ-1:0]   gate_q;
   logic [DLY_W-1:0]    cnt_q [NUM_EQ];

   // sequencer
   logic [EQ_IDX_W-1:0] eq_idx_q;
   logic                pass_done_q;

   // combinational evaluation of the current slot
   logic [SIG_COUNT-1:0] sig_list;
   logic [31:0]          cur_cfg;
   logic [31:0]          cur_rst;
   logic [31:0]          cur_dly;
   logic [NUM_IN-1:0]    cond;
   logic                 gate_d;
   logic [DLY_W-1:0]     need_dly;
   logic                 res_d;
   logic [DLY_W-1:0]     cnt_d;
   logic                 rst_active;
   logic                 lat_d;

   // apb decode
   logic                 apb_setup;
   logic                 apb_write;
   logic [EQ_IDX_W-1:0]  bus_idx;
   logic [3:0]           bus_ofs;
   logic [31:0]          rd_word;
   logic [31:0]          prdata_q;
   logic                 pslverr_q;

   // signal groups joined into one external vector
   assign ext_raw = {module_input_in, alarm_in, breaker_state_in, prot_state_in, pickup_in};

   // two flip-flop synchroniser on every external signal
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
      end else begin
         ext_s1_q <= ext_raw;
         ext_s2_q <= ext_s1_q;
      end
   end

   // slot sequencer stepping upward and wrapping to slot zero
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         eq_idx_q <= '0;
      end else begin
         eq_idx_q <= eq_idx_q + 1'b1;
      end
   end

   // one cycle pulse when the highest slot has been evaluated
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         pass_done_q <= 1'b0;
      end else begin
         pass_done_q <= (eq_idx_q == EQ_IDX_W'(NUM_EQ - 1));
      end
   end

   // signal list: stored results are read live, so lower slots already hold
   // this pass's value and higher slots still hold the previous pass's value
   assign sig_list = {lat_q, res_q, ext_s2_q};

   // configuration words of the slot under evaluation
   assign cur_cfg = cfg_q[eq_idx_q];
   assign cur_rst = rst_q[eq_idx_q];
   assign cur_dly = dly_q[eq_idx_q];

   // one selection and inversion stage for each gate input
   for (genvar gi = 0; gi < NUM_IN; gi++) begin : g_cond
      assign cond[gi] = cond_signal(sig_list,
                                    cur_cfg[CFG_SEL_POS + gi*SIG_W +: SIG_W],
                                    cur_cfg[CFG_INV_POS + gi]);
   end

   // gate for the slot under evaluation
   assign gate_d = gate_eval(cur_cfg[CFG_OP_POS +: 2], cond);

   // on and off delay: count passes while the gate differs from the output;
   // a count left from a short glitch is dropped as soon as the gate agrees
   always_comb begin
      need_dly = res_q[eq_idx_q] ? cur_dly[DLY_OFF_POS +: DLY_W]
                                 : cur_dly[DLY_ON_POS +: DLY_W];
      res_d    = res_q[eq_idx_q];
      cnt_d    = CNT_RESET;
      if (gate_d != res_q[eq_idx_q]) begin
         if (cnt_q[eq_idx_q] >= need_dly) begin
            res_d = gate_d;
         end else begin
            cnt_d = cnt_q[eq_idx_q] + 1'b1;
         end
      end
   end

   // reset-dominant latch fed by the delayed result
   always_comb begin
      rst_active = cond_signal(sig_list, cur_rst[RST_SEL_POS +: SIG_W], cur_rst[RST_INV_POS]);
      if (rst_active) begin
         lat_d = 1'b0;
      end else if (res_d) begin
         lat_d = 1'b1;
      end else begin
         lat_d = lat_q[eq_idx_q];
      end
   end

   // store the new state of the evaluated slot only
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         res_q  <= '0;
         lat_q  <= '0;
         gate_q <= '0;
      end else begin
         res_q[eq_idx_q]  <= res_d;
         lat_q[eq_idx_q]  <= lat_d;
         gate_q[eq_idx_q] <= gate_d;
      end
   end

   // complemented latch kept in flip-flops of its own, written with the latch
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         lat_inv_q <= '1;
      end else begin
         lat_inv_q[eq_idx_q] <= ~lat_d;
      end
   end

   // timer counters, one per slot
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         for (int i = 0; i < NUM_EQ; i++) begin
            cnt_q[i] <= CNT_RESET;
         end
      end else begin
         cnt_q[eq_idx_q] <= cnt_d;
      end
   end

   // equation outputs straight from the state flip-flops
   assign equation_result_output_out = res_q;
   assign latched_result_out         = lat_q;
   assign latched_result_inv_out     = lat_inv_q;
   assign pass_done_out              = pass_done_q;

   // apb phase and address decode
   assign apb_setup = psel_in && !penable_in;
   assign apb_write = psel_in && penable_in && pwrite_in && addr_mapped(paddr_in);
   assign bus_idx   = paddr_in[EQ_IDX_W+3:4];
   assign bus_ofs   = paddr_in[3:0];

   // configuration writes, taken in the access phase
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         for (int i = 0; i < NUM_EQ; i++) begin
            cfg_q[i] <= CFG_RESET;
            rst_q[i] <= RST_RESET;
            dly_q[i] <= DLY_RESET;
         end
      end else if (apb_write) begin
         unique case (bus_ofs)
            OFS_CFG: begin
               cfg_q[bus_idx] <= pwdata_in;
            end
            OFS_RST: begin
               rst_q[bus_idx] <= pwdata_in;
            end
            OFS_DLY: begin
               dly_q[bus_idx] <= pwdata_in;
            end
            default: begin
               // status word is read only
            end
         endcase
      end
   end

   // read word selection, unused configuration bits read back as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (bus_ofs)
         OFS_CFG: begin
            rd_word[CFG_OP_POS+1:0] = cfg_q[bus_idx][CFG_OP_POS+1:0];
         end
         OFS_RST: begin
            rd_word[RST_SEL_POS +: SIG_W] = rst_q[bus_idx][RST_SEL_POS +: SIG_W];
            rd_word[RST_INV_POS]          = rst_q[bus_idx][RST_INV_POS];
         end
         OFS_DLY: begin
            rd_word = dly_q[bus_idx];
         end
         OFS_STAT: begin
            rd_word[STAT_RES_POS]           = res_q[bus_idx];
            rd_word[STAT_LAT_POS]           = lat_q[bus_idx];
            rd_word[STAT_GATE_POS]          = gate_q[bus_idx];
            rd_word[STAT_CNT_POS +: DLY_W]  = cnt_q[bus_idx];
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // read data and error captured in the setup phase for a zero wait answer;
   // status bits therefore show the state at the setup edge, one clock
   // before the master takes them
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (apb_setup) begin
         prdata_q  <= addr_mapped(paddr_in) ? rd_word : 32'h0000_0000;
         pslverr_q <= !addr_mapped(paddr_in);
      end
   end

   // every access completes in its first access cycle
   assign pready_out  = psel_in && penable_in;
   assign prdata_out  = prdata_q;
   assign pslverr_out = pslverr_q && psel_in && penable_in;

endmodule

`default_nettype wire

// ==== verif/ext_signal_model.sv ====
/* far-side model: pickups, states, breaker, alarms, module inputs as levels.
   assumes the bench sets level_in off the sampling edge. */
`timescale 1ns/1ps
`default_nettype none
module ext_signal_model (
   input  wire logic [15:0] level_in,
   output logic      [3:0]  pickup_out,
   output logic      [3:0]  prot_state_out,
   output logic      [1:0]  breaker_state_out,
   output logic      [1:0]  alarm_out,
   output logic      [3:0]  module_input_out
);
   // split the level word into groups in list order
   assign pickup_out        = level_in[3:0];
   assign prot_state_out    = level_in[7:4];
   assign breaker_state_out = level_in[9:8];
   assign alarm_out         = level_in[11:10];
   assign module_input_out  = level_in[15:12];
endmodule
`default_nettype wire

// ==== verif/logic_equation_engine_assertions.sv ====
/* checker: slot timing, latch and apb answer of the engine.
   assumes binding to the engine top module. */
`timescale 1ns/1ps
`default_nettype none
module engine_checker
   import logic_equation_engine_pkg::*;
(
   input wire logic              mclk_in,
   input wire logic              reset_in,
   input wire logic [NUM_EQ-1:0] equation_result_output_out,
   input wire logic [NUM_EQ-1:0] latched_result_out,
   input wire logic [NUM_EQ-1:0] latched_result_inv_out,
   input wire logic              pass_done_out,
   input wire logic              psel_in,
   input wire logic              penable_in,
   input wire logic              pready_out,
   input wire logic              pslverr_out
);
   // one clock domain
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   property p_inv; latched_result_inv_out == ~latched_result_out; endproperty
   a_inv: assert property (p_inv) else $error("inverted latch wrong");
   property p_pass; pass_done_out |=> !pass_done_out [*7] ##1 pass_done_out; endproperty
   a_pass: assert property (p_pass) else $error("pass length wrong");
   property p_slot0; $changed(equation_result_output_out[0]) |-> $past(pass_done_out); endproperty
   a_slot0: assert property (p_slot0) else $error("slot 0 off its turn");
   property p_slot1; $changed(equation_result_output_out[1]) |-> $past(pass_done_out, 2); endproperty
   a_slot1: assert property (p_slot1) else $error("slot 1 off its turn");
   property p_lat0; $changed(latched_result_out[0]) |-> $past(pass_done_out); endproperty
   a_lat0: assert property (p_lat0) else $error("latch off its turn");
   property p_set; $rose(latched_result_out[0]) |-> equation_result_output_out[0]; endproperty
   a_set: assert property (p_set) else $error("latch set without result");
   property p_ready; pready_out == (psel_in && penable_in); endproperty
   a_ready: assert property (p_ready) else $error("pready wrong");
   property p_err; pslverr_out |-> psel_in && penable_in; endproperty
   a_err: assert property (p_err) else $error("pslverr outside access");
endmodule
bind logic_equation_engine engine_checker i_engine_checker (.mclk_in(mclk_in), .reset_in(reset_in),
   .equation_result_output_out(equation_result_output_out), .latched_result_out(latched_result_out),
   .latched_result_inv_out(latched_result_inv_out), .pass_done_out(pass_done_out),
   .psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out), .pslverr_out(pslverr_out));
`default_nettype wire

// ==== verif/logic_equation_engine_tb.sv ====
/* bench for the logic equation engine over apb.
   assumes the 20 MHz clock and 2-clock input sync. */
`timescale 1ns/1ps
`default_nettype none
module logic_equation_engine_tb;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, pdone, er;
   logic [7:0]  paddr, res, lat, linv;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] lvl;
   logic [3:0]  pu, pst, mi;
   logic [1:0]  brk, alm;
   int          n_mismatch, n_checks;

   ext_signal_model i_ext_signal_model (.level_in(lvl), .pickup_out(pu), .prot_state_out(pst),
      .breaker_state_out(brk), .alarm_out(alm), .module_input_out(mi));
   logic_equation_engine i_logic_equation_engine (.mclk_in(clk), .reset_in(rst), .pickup_in(pu),
      .prot_state_in(pst), .breaker_state_in(brk), .alarm_in(alm), .module_input_in(mi),
      .equation_result_output_out(res), .latched_result_out(lat), .latched_result_inv_out(linv),
      .pass_done_out(pdone), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr));

   // 50 ns clock
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_mismatch++;
         print_verdict();
      end
   endtask

   // values after reset and two refused addresses
   task automatic t_reset();
      chk({res, lat, linv}, 32'h0000_00ff);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h80, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      apb(1'b0, 8'h02, 32'h0);
      chk({rd[30:0], er}, 32'h1);
      $display("reset test done");
   endtask

   // every gate operator with input 3 inverted
   task automatic t_gate();
      logic [3:0] c;
      for (int p = 0; p < 2; p++)
         for (int op = 0; op < 4; op++) begin
            lvl <= p ? 16'h0007 : 16'h0000;
            apb(1'b1, 8'h00, 32'h0081_8820 | (op << 24));
            cyc(32);
            c = p ? 4'hf : 4'h8;
            chk(res[0], (op[0] ? |c : &c) ^ op[1]);
         end
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0381_8820);
      $display("gate test done");
   endtask

   // on delay 3 passes, off delay 1 pass
   task automatic t_delay();
      apb(1'b1, 8'h08, 32'h0001_0003);
      apb(1'b1, 8'h00, 32'h0081_8820);
      lvl <= 16'h0000;
      cyc(32);
      lvl <= 16'h0007;
      cyc(20);
      chk(res[0], 1'b0);
      cyc(28);
      chk(res[0], 1'b1);
      lvl <= 16'h0000;
      cyc(8);
      chk(res[0], 1'b1);
      cyc(24);
      chk(res[0], 1'b0);
      apb(1'b1, 8'h08, 32'h0);
      $display("delay test done");
   endtask

   // latch reset from module input 0, reset dominant, then inverted reset
   task automatic t_latch();
      apb(1'b1, 8'h04, 32'h0000_000c);
      lvl <= 16'h0007;
      cyc(32);
      chk({res[0], lat[0], linv[0]}, 32'h6);
      lvl <= 16'h0000;
      cyc(32);
      chk({res[0], lat[0], linv[0]}, 32'h2);
      lvl <= 16'h1007;
      cyc(32);
      chk({res[0], lat[0], linv[0]}, 32'h5);
      lvl <= 16'h0007;
      cyc(32);
      chk({res[0], lat[0], linv[0]}, 32'h6);
      apb(1'b1, 8'h04, 32'h0000_010c);
      cyc(32);
      chk({res[0], lat[0], linv[0]}, 32'h5);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0000_0005);
      apb(1'b1, 8'h0c, 32'hffff_ffff);
      apb(1'b0, 8'h0c, 32'h0);
      chk({rd[30:0], er}, 32'h0000_000a);
      $display("latch test done");
   endtask

   // slot 1 follows slot 0 within the same pass
   task automatic t_chain();
      int k;
      apb(1'b1, 8'h10, 32'h0008_4210);
      cyc(32);
      chk(res[1], 1'b1);
      lvl <= 16'h0000;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (res[0] !== 1'b0 && k < 40);
      chk(k < 40, 1'b1);
      if (k >= 40) begin
         print_verdict();
      end
      chk(res[1], 1'b1);
      @(negedge clk);
      chk(res[1], 1'b0);
      $display("chain test done");
   endtask

   // slot 1 fed by slot 2 sees the new result only one pass later
   task automatic t_desc();
      int k;
      apb(1'b1, 8'h10, 32'h0009_4a52);
      apb(1'b1, 8'h20, 32'h0100_0000);
      cyc(32);
      chk(res[2:1], 2'b00);
      lvl <= 16'h0001;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (res[2] !== 1'b1 && k < 40);
      chk(k < 40, 1'b1);
      if (k >= 40) begin
         print_verdict();
      end
      repeat (6) @(negedge clk);
      chk(res[1], 1'b0);
      @(negedge clk);
      chk(res[1], 1'b1);
      $display("descending chain test done");
   endtask

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      lvl = 16'h0000;
      n_mismatch = 0;
      n_checks = 0;
      cyc(16);
      rst <= 1'b0;
      t_reset();
      t_gate();
      t_delay();
      t_latch();
      t_chain();
      t_desc();
      print_verdict();
   end
endmodule
`default_nettype wire
